/* bench/rsfc_node_model.sv */
/*
  Ring node partner: takes symbols from the host's upstream link and
  drives the downstream link from a queue, with nulls when idle.
  Assumes each upstream slot lasts SC host clocks of 10 ns.
*/
`timescale 1ns/100ps
`default_nettype none
module rsfc_node_model
  import rsfc_pkg::*;
#(
  parameter int SC = 2
)(
  // Upstream link from the host
  input  wire logic             up_clk_in,
  input  wire logic [SUB_W-1:0] up_bus_in,
  // Downstream link to the host
  output logic                  dn_clk_out,
  output logic [SUB_W-1:0]      dn_bus_out,
  // Abort indication toward the client
  output logic                  abort_out
);
  logic [SYM_W-1:0] rx_q[$];
  logic [SYM_W-1:0] dn_q[$];
  logic [SYM_W-1:0] s;
  logic [SYM_W-1:0] d;

  always @(posedge up_clk_in) begin
    #(SC * 5);
    for (int i = 0; i < SUB_PER_SYM; i++) begin
      s = {s[SYM_W-SUB_W-1:0], up_bus_in};
      if (i < SUB_PER_SYM - 1) #(SC * 10);
    end
    if (!(s[KIND_HI:KIND_LO] == KIND_ACCESS && s[ACC_HI+7:ACC_LO+7] == ACC_NULL))
      rx_q.push_back(s);
    if (s[KIND_HI:KIND_LO] == KIND_ACCESS && s[ACC_HI+7:ACC_LO+7] == ACC_ABORT) begin
      dn_q.push_back(s);
      abort_out = 1'b1;
    end
  end

  // One symbol per tick, null when idle
  initial begin
    dn_clk_out = 1'b0;
    dn_bus_out = 6'h00;
    abort_out = 1'b0;
    #3;
    forever begin
      d = dn_q.size() ? dn_q.pop_front() : {KIND_ACCESS, 1'b1, ACC_NULL, ROUTE_BLANK, EDC_FILL};
      for (int i = 0; i < SUB_PER_SYM; i++) begin
        dn_bus_out = d[SYM_W-1-SUB_W*i -: SUB_W];
        dn_clk_out = (i < CLK_HIGH_SLOTS);
        #20;
      end
    end
  end
endmodule // rsfc_node_model
`default_nettype wire

/* bench/test_rsfc_ring_host.sv */
/*
  Testbench for the ring host: drives AXI4-Lite, sends symbols to the
  node partner and checks them; injects downstream symbols and aborts.
  Assumes the partner's downstream clock runs at 140 ns.
*/
`timescale 1ns/100ps
`default_nettype none
module test_rsfc_ring_host;
  import rsfc_pkg::*;
  logic        ref_clk, reset;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, up_clk, dn_clk, abort;
  logic [1:0]  bresp, rresp, r;
  logic [5:0]  up_bus, dn_bus;
  logic [41:0] e;
  int          n_fail, cmp_count, cyc;

  rsfc_ring_host #(.SUB_CYCLES(4'h2)) u_rsfc_ring_host (
    .ref_clk_in(ref_clk), .reset_in(reset),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .up_link_clk_out(up_clk),
    .upstream_subsymbol_bus_out(up_bus), .dn_link_clk_in(dn_clk),
    .downstream_subsymbol_bus_in(dn_bus));
  rsfc_node_model #(.SC(2)) u_rsfc_node_model (
    .up_clk_in(up_clk), .up_bus_in(up_bus), .dn_clk_out(dn_clk),
    .dn_bus_out(dn_bus), .abort_out(abort));

  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      end_of_test();
    end
  end

  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test();
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // AXI4-Lite write, valid held until each channel is taken
  task wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
    logic bh;
    @(posedge ref_clk);
    awaddr <= a; wdata <= dt; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      bh = bvalid; rs = bresp;
    end
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
    logic dn;
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    dn = 1'b0;
    while (!dn) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      dn = rvalid; dt = rdata; rs = rresp;
    end
    rready <= 1'b0;
  endtask
  // Send one symbol and compare with what the node received
  task send(input logic [1:0] k, input logic f, input logic [1:0] ac, input logic [29:0] rt);
    logic [31:0] dt;
    dt = $urandom;
    wr(REG_ROUTE, {2'h0, rt}, r);
    wr(REG_TX_DATA, dt, r);
    wr(REG_TX_CMD, {27'h0, ac, f, k}, r);
    chk("cmd_resp", r, RESP_OKAY);
    e = {k, f, (k == KIND_HEAD) ? {HEAD_ACC, rt} : (k == KIND_ACCESS) ?
         {ac, (ac == ACC_ABORT) ? ROUTE_BLANK : rt} : dt, EDC_FILL};
    for (int i = 0; i < 200 && u_rsfc_node_model.rx_q.size() == 0; i++) @(posedge ref_clk);
    chk("up_sym", u_rsfc_node_model.rx_q.size() ? u_rsfc_node_model.rx_q.pop_front() : 0, e);
  endtask
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    for (int i = 0; i < 60 && (v & m) !== x; i++) rd(a, v, r);
  endtask

  initial begin
    awaddr = 0; araddr = 0; wdata = 0; awvalid = 0; wvalid = 0; bready = 0;
    arvalid = 0; rready = 0; reset = 1'b1; n_fail = 0; cmp_count = 0; cyc = 0; v = 0;
    void'($urandom(32'h7a69));
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    // Reset values and unmapped address
    rd(REG_ROUTE, v, r); chk("route_rst", v, WORD_RST);
    rd(REG_TX_DATA, v, r); chk("data_rst", v, WORD_RST);
    rd(8'h20, v, r); chk("unmapped_resp", r, RESP_SLVERR);
    wr(8'h24, 32'h0, r); chk("unmapped_wr", r, RESP_SLVERR);
    // Every kind, both frame values, both classes, voucher and ticket
    for (int k = 0; k < 8; k++)
      send(k / 2, (k / 2 == 1 || k / 2 == 2) ? k % 2 : 0, 1 + k % 2, {2'(k % 2), 28'($urandom)});
    // Abort is forwarded back round and flagged, then cleared
    send(KIND_ACCESS, 1'b0, ACC_ABORT, 30'h0);
    v = 0; poll(REG_STATUS, 32'h4, 32'h4);
    chk("abort_flag", v[STAT_ABORT], 1'b1);
    chk("abort_out", abort, 1'b1);
    wr(REG_STATUS, 32'h4, r);
    rd(REG_STATUS, v, r); chk("abort_clr", v[STAT_ABORT], 1'b0);
    // Downstream tail symbol decoded from slot t onward
    e = {KIND_TAIL, 1'b1, 32'($urandom), EDC_FILL};
    repeat (2) u_rsfc_node_model.dn_q.push_back(e);
    v = 0; poll(REG_RX_WORD, 32'hFFFFFFFF, e[38:7]);
    chk("rx_word", v, e[38:7]);
    rd(REG_RX_INFO, v, r); chk("rx_info", v[2:0], {KIND_TAIL, 1'b1});
    // Reserved class in a received head
    u_rsfc_node_model.dn_q.push_back({KIND_HEAD, 1'b0, 2'h0, 2'h2, 28'($urandom), EDC_FILL});
    v = 0; poll(REG_STATUS, 32'h8, 32'h8);
    chk("resv_class", v[STAT_RESV], 1'b1);
    end_of_test();
  end
endmodule // test_rsfc_ring_host
`default_nettype wire

/* common/rsfc_pkg.sv */
/*
  Shared constants for the ring symbol field controller: symbol layout,
  kind, access and class codes, link framing and the register map.
  Assumes a 42-bit ring symbol sent as seven 6-bit sub-symbols.
*/
package rsfc_pkg;
  // Symbol geometry
  localparam int SUB_W       = 6;
  localparam int SUB_PER_SYM = 7;
  localparam int SYM_W       = 42;
  localparam int WORD_W      = 32;
  localparam int EDC_W       = 7;
  localparam int ROUTE_W     = 30;
  localparam int HOPS_W      = 20;
  localparam int NODE_W      = 4;

  // Bit positions within the symbol and its word
  localparam int KIND_HI   = 41;
  localparam int KIND_LO   = 40;
  localparam int FRAME_BIT = 39;
  localparam int WORD_HI   = 38;
  localparam int WORD_LO   = 7;
  localparam int ACC_HI    = 31;
  localparam int ACC_LO    = 30;
  localparam int CONN_HI   = 29;
  localparam int CONN_LO   = 28;
  localparam int SRCE_HI   = 27;
  localparam int SRCE_LO   = 24;
  localparam int TRGT_HI   = 23;
  localparam int TRGT_LO   = 20;
  localparam int HOPS_HI   = 19;

  // Symbol kind codes
  localparam logic [1:0] KIND_HEAD    = 2'h0;
  localparam logic [1:0] KIND_PAYLOAD = 2'h1;
  localparam logic [1:0] KIND_TAIL    = 2'h2;
  localparam logic [1:0] KIND_ACCESS  = 2'h3;

  // Access codes
  localparam logic [1:0] ACC_ABORT   = 2'h0;
  localparam logic [1:0] ACC_VOUCHER = 2'h1;
  localparam logic [1:0] ACC_TICKET  = 2'h2;
  localparam logic [1:0] ACC_NULL    = 2'h3;
  localparam logic [1:0] HEAD_ACC    = 2'h0;

  // Connection classes
  localparam logic [1:0] CONN_NORMAL = 2'h0;
  localparam logic [1:0] CONN_LOW_BW = 2'h1;

  // Check field filler and blank route
  localparam logic [EDC_W-1:0]   EDC_FILL    = 7'h00;
  localparam logic [ROUTE_W-1:0] ROUTE_BLANK = 30'h0000_0000;

  // Link clock is high during the first slots of each symbol
  localparam int CLK_HIGH_SLOTS = 4;

  // Register map and fields
  localparam logic [7:0]  REG_TX_CMD  = 8'h00;
  localparam logic [7:0]  REG_ROUTE   = 8'h04;
  localparam logic [7:0]  REG_TX_DATA = 8'h08;
  localparam logic [7:0]  REG_STATUS  = 8'h0C;
  localparam logic [7:0]  REG_RX_WORD = 8'h10;
  localparam logic [7:0]  REG_RX_INFO = 8'h14;
  localparam int          CMD_KIND_LO = 0;
  localparam int          CMD_FRAME   = 2;
  localparam int          CMD_ACC_LO  = 3;
  localparam int          STAT_BUSY   = 0;
  localparam int          STAT_RXV    = 1;
  localparam int          STAT_ABORT  = 2;
  localparam int          STAT_RESV   = 3;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

/* common/rsfc_sym_if.sv */
/*
  Carrier between the ring host and its field codec: fields to encode,
  symbol to decode, and the decoded fields.
  Assumes both ends run on the host clock carried here.
*/
`timescale 1ns/100ps
`default_nettype none
interface rsfc_sym_if import rsfc_pkg::*; ;
  logic                clk;
  logic                rst;
  logic [1:0]          tx_kind;
  logic                tx_frame;
  logic [1:0]          tx_acc;
  logic [ROUTE_W-1:0]  tx_route;
  logic [WORD_W-1:0]   tx_data;
  logic [SYM_W-1:0]    tx_sym;
  logic [SYM_W-1:0]    rx_sym;
  logic [1:0]          rx_kind;
  logic                rx_frame;
  logic [1:0]          rx_acc;
  logic [1:0]          rx_conn;
  logic [NODE_W-1:0]   rx_srce;
  logic [NODE_W-1:0]   rx_trgt;
  logic [HOPS_W-1:0]   rx_hops;
  logic [WORD_W-1:0]   rx_word;
  logic                rx_abort;
  logic                rx_resv_conn;

  modport codec (
    input  clk, rst, tx_kind, tx_frame, tx_acc, tx_route, tx_data, rx_sym,
    output tx_sym, rx_kind, rx_frame, rx_acc, rx_conn, rx_srce, rx_trgt,
    output rx_hops, rx_word, rx_abort, rx_resv_conn
  );
  modport user (
    output clk, rst, tx_kind, tx_frame, tx_acc, tx_route, tx_data, rx_sym,
    input  tx_sym, rx_kind, rx_frame, rx_acc, rx_conn, rx_srce, rx_trgt,
    input  rx_hops, rx_word, rx_abort, rx_resv_conn
  );
endinterface
`default_nettype wire

/* hw/rsfc_field_codec.sv */
/*
  Field codec: packs kind, frame, access code, route and data into a
  42-bit ring symbol, and splits a received symbol into its fields.
  Assumes the user holds its inputs stable while the symbol is loaded.
*/
`timescale 1ns/100ps
`default_nettype none
module rsfc_field_codec
  import rsfc_pkg::*;
(
  // Symbol fields in both directions
  rsfc_sym_if.codec s
);
  logic [WORD_W-1:0] word;
  logic              frame;

  // Encode the outgoing word and frame flag per kind
  always_comb begin
    word  = WORD_RST;
    frame = 1'b0;
    case (s.tx_kind)
      KIND_HEAD: begin
        word = {HEAD_ACC, s.tx_route};
      end
      KIND_PAYLOAD, KIND_TAIL: begin
        word  = s.tx_data;
        frame = s.tx_frame;
      end
      KIND_ACCESS: begin
        if (s.tx_acc == ACC_NULL || s.tx_acc == ACC_ABORT) begin
          word = {s.tx_acc, ROUTE_BLANK};
        end else begin
          word = {s.tx_acc, s.tx_route};
        end
        frame = (s.tx_acc == ACC_NULL);
      end
      default: begin
        word = WORD_RST;
      end
    endcase
  end

  assign s.tx_sym = {s.tx_kind, frame, word, EDC_FILL};

  assign s.rx_kind      = s.rx_sym[KIND_HI:KIND_LO];
  assign s.rx_frame     = s.rx_sym[FRAME_BIT];
  assign s.rx_word      = s.rx_sym[WORD_HI:WORD_LO];
  assign s.rx_acc       = s.rx_word[ACC_HI:ACC_LO];
  assign s.rx_conn      = s.rx_word[CONN_HI:CONN_LO];
  assign s.rx_srce      = s.rx_word[SRCE_HI:SRCE_LO];
  assign s.rx_trgt      = s.rx_word[TRGT_HI:TRGT_LO];
  assign s.rx_hops      = s.rx_word[HOPS_HI:0];
  // abort is access kind, code zero
  assign s.rx_abort     = (s.rx_kind == KIND_ACCESS) && (s.rx_acc == ACC_ABORT);
  assign s.rx_resv_conn = (s.rx_kind == KIND_HEAD) &&
                          (s.rx_conn != CONN_NORMAL) && (s.rx_conn != CONN_LOW_BW);

  a_head_layout: assert property (@(posedge s.clk) disable iff (s.rst)
    s.tx_kind == KIND_HEAD |-> !s.tx_sym[FRAME_BIT] &&
      s.tx_sym[WORD_LO+ACC_HI -: 2] == 2'h0 &&
      s.tx_sym[WORD_LO+CONN_HI -: 2] == s.tx_route[CONN_HI:CONN_LO])
    else $error("head symbol layout wrong");

  a_null_frame: assert property (@(posedge s.clk) disable iff (s.rst)
    s.tx_kind == KIND_ACCESS |->
      s.tx_sym[FRAME_BIT] == (s.tx_sym[WORD_LO+ACC_HI -: 2] == ACC_NULL) &&
      s.tx_sym[WORD_LO+ACC_HI -: 2] == s.tx_acc)
    else $error("access symbol frame or code wrong");

  a_payload_word: assert property (@(posedge s.clk) disable iff (s.rst)
    (s.tx_kind == KIND_PAYLOAD || s.tx_kind == KIND_TAIL) |->
      s.tx_sym[WORD_HI:WORD_LO] == s.tx_data && s.tx_sym[FRAME_BIT] == s.tx_frame)
    else $error("payload word or frame lost");

  a_route_target: assert property (@(posedge s.clk) disable iff (s.rst)
    s.tx_kind == KIND_HEAD |->
      s.tx_sym[WORD_LO+TRGT_HI -: NODE_W] == s.tx_route[TRGT_HI:TRGT_LO] &&
      s.tx_sym[WORD_LO+SRCE_HI -: NODE_W] == s.tx_route[SRCE_HI:SRCE_LO])
    else $error("target or source field misplaced");
endmodule // rsfc_field_codec
`default_nettype wire

/* hw/rsfc_ring_host.sv */
/*
  Ring host: a neighbour node that sends symbols into a ring node's
  upstream port and reads symbols from its downstream port, steered by
  software over AXI4-Lite.
  Assumes the node's downstream clock rises at the start of sub-symbol t
  and that its period spans at least 14 host clocks.
*/
// Notes on behaviour
// - Kind codes: head, payload, tail, access
// - Data and frame share payload code
// - Access codes: abort, voucher, ticket, null
// - Client ports carry access code zero
// - Class: normal, low bandwidth, two reserved
// - Target field holds target node id
// - Source field holds source node id
// - Five hop tags separate shared routes
// - Kind field travels in first sub-symbol
// - Head layout: class, source, target, hops
`timescale 1ns/100ps
`default_nettype none
module rsfc_ring_host
  import rsfc_pkg::*;
#(
  parameter logic [3:0] SUB_CYCLES = 4'h2  // Host clocks per sent sub-symbol
)(
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             reset_in,
  // AXI4-Lite write channels
  input  wire logic [7:0]       s_axi_awaddr_in,
  input  wire logic             s_axi_awvalid_in,
  output logic                  s_axi_awready_out,
  input  wire logic [31:0]      s_axi_wdata_in,
  input  wire logic [3:0]       s_axi_wstrb_in,
  input  wire logic             s_axi_wvalid_in,
  output logic                  s_axi_wready_out,
  output logic [1:0]            s_axi_bresp_out,
  output logic                  s_axi_bvalid_out,
  input  wire logic             s_axi_bready_in,
  // AXI4-Lite read channels
  input  wire logic [7:0]       s_axi_araddr_in,
  input  wire logic             s_axi_arvalid_in,
  output logic                  s_axi_arready_out,
  output logic [31:0]           s_axi_rdata_out,
  output logic [1:0]            s_axi_rresp_out,
  output logic                  s_axi_rvalid_out,
  input  wire logic             s_axi_rready_in,
  // Link into the node's upstream port
  output logic                  up_link_clk_out,
  output logic [SUB_W-1:0]      upstream_subsymbol_bus_out,
  // Link from the node's downstream port
  input  wire logic             dn_link_clk_in,
  input  wire logic [SUB_W-1:0] downstream_subsymbol_bus_in
);
  typedef struct packed {
    logic              aw_have;
    logic [7:0]        aw_addr;
    logic              w_have;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [ROUTE_W-1:0] route;
    logic [31:0]       tx_data;
    logic [1:0]        cmd_kind;
    logic              cmd_frame;
    logic [1:0]        cmd_acc;
    logic              pend;
    logic [3:0]        sub_cnt;
    logic [2:0]        slot;
    logic [SYM_W-1:0]  sh;
    logic              clk_out;
    logic [SUB_W-1:0]  bus_out;
    logic              ck_m;
    logic              ck_s;
    logic              ck_p;
    logic [SUB_W-1:0]  bus_m;
    logic [SUB_W-1:0]  bus_s;
    logic [7:0]        rx_cnt;
    logic [7:0]        period;
    logic [2:0]        rx_slot;
    logic [SYM_W-1:0]  rx_sh;
    logic [SYM_W-1:0]  rx_sym;
    logic              rx_new;
    logic              rx_valid;
    logic              abort_seen;
    logic              resv_seen;
  } rsfc_state_t;

  localparam logic [2:0] LAST_SLOT = 3'(SUB_PER_SYM - 1);
  localparam logic [2:0] HIGH_END  = 3'(CLK_HIGH_SLOTS);
  localparam logic [7:0] CNT_MAX   = 8'hFF;
  localparam logic [7:0] SLOT_MUL  = 8'(2 * SUB_PER_SYM);

  rsfc_state_t q;
  rsfc_state_t d;
  rsfc_sym_if  sym ();

  logic [3:0]  nxt_sub;
  logic [2:0]  nxt_slot;
  logic        sym_start;
  logic        ck_rise;
  logic [15:0] smp_lhs;
  logic [15:0] smp_rhs;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] rd_val;
  logic        rd_hit;

  // Field codec shared by transmit and receive
  rsfc_field_codec u_codec (
    .s (sym.codec)
  );

  // Idle slots carry null access symbols, else the pending command
  assign sym.clk      = ref_clk_in;
  assign sym.rst      = reset_in;
  assign sym.tx_kind  = q.pend ? q.cmd_kind : KIND_ACCESS;
  assign sym.tx_acc   = q.pend ? q.cmd_acc : ACC_NULL;
  assign sym.tx_frame = q.cmd_frame;
  assign sym.tx_route = q.route;
  assign sym.tx_data  = q.tx_data;
  assign sym.rx_sym   = q.rx_sym;

  // Transmit slot timing
  assign nxt_sub   = (q.sub_cnt == SUB_CYCLES - 4'h1) ? 4'h0 : q.sub_cnt + 4'h1;
  assign nxt_slot  = (nxt_sub != 4'h0) ? q.slot :
                     (q.slot == LAST_SLOT) ? 3'h0 : q.slot + 3'h1;
  assign sym_start = (nxt_sub == 4'h0) && (nxt_slot == 3'h0);

  // Receive sampling point: middle of each sub-symbol of the measured period
  assign ck_rise = q.ck_s && !q.ck_p;
  // The count lags the sampled bus by one clock, so count one ahead
  assign smp_lhs = (16'(q.rx_cnt) + 16'h1) * 16'(SLOT_MUL);
  assign smp_rhs = 16'({q.rx_slot, 1'b1}) * 16'(q.period);

  // Bus handshakes
  assign s_axi_awready_out = !q.aw_have;
  assign s_axi_wready_out  = !q.w_have;
  assign s_axi_arready_out = !q.rvalid;
  assign s_axi_bvalid_out  = q.bvalid;
  assign s_axi_bresp_out   = q.bresp;
  assign s_axi_rvalid_out  = q.rvalid;
  assign s_axi_rdata_out   = q.rdata;
  assign s_axi_rresp_out   = q.rresp;
  assign wr_go = q.aw_have && q.w_have && !q.bvalid;
  assign rd_go = s_axi_arvalid_in && !q.rvalid;

  // Link outputs come straight from flip-flops
  assign up_link_clk_out            = q.clk_out;
  assign upstream_subsymbol_bus_out = q.bus_out;

  // Register read mux
  always_comb begin
    rd_val = WORD_RST;
    rd_hit = 1'b1;
    case (s_axi_araddr_in & 8'hFC)
      REG_TX_CMD:  rd_val = 32'({q.cmd_acc, q.cmd_frame, q.cmd_kind});
      REG_ROUTE:   rd_val = 32'(q.route);
      REG_TX_DATA: rd_val = q.tx_data;
      REG_STATUS:  rd_val = 32'({q.resv_seen, q.abort_seen, q.rx_valid, q.pend});
      REG_RX_WORD: rd_val = sym.rx_word;
      REG_RX_INFO: rd_val = 32'({sym.rx_acc, sym.rx_kind, sym.rx_frame});
      default:     rd_hit = 1'b0;
    endcase
  end

  // Next-state logic
  always_comb begin
    d = q;
    // Write address and data are taken in either order
    if (s_axi_awvalid_in && !q.aw_have) begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !q.w_have) begin
      d.w_have = 1'b1;
      d.w_data = s_axi_wdata_in;
      d.w_strb = s_axi_wstrb_in;
    end
    if (q.bvalid && s_axi_bready_in) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready_in) begin
      d.rvalid = 1'b0;
    end
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_val;
      d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // Transmit: load a new symbol at each symbol start
    d.sub_cnt = nxt_sub;
    d.slot    = nxt_slot;
    d.clk_out = (nxt_slot < HIGH_END);
    if (nxt_sub == 4'h0) begin
      if (sym_start) begin
        // kind goes out in slot t
        d.bus_out = sym.tx_sym[SYM_W-1 -: SUB_W];
        d.sh      = sym.tx_sym << SUB_W;
        d.pend    = 1'b0;
      end else begin
        d.bus_out = q.sh[SYM_W-1 -: SUB_W];
        d.sh      = q.sh << SUB_W;
      end
    end

    // Register writes; a command is refused while one is pending and not loaded this cycle
    if (wr_go) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      case (q.aw_addr & 8'hFC)
        REG_TX_CMD: begin
          if (q.pend && !sym_start) begin
            d.bresp = RESP_SLVERR;
          end else if (q.w_strb[0]) begin
            d.cmd_kind  = q.w_data[CMD_KIND_LO +: 2];
            d.cmd_frame = q.w_data[CMD_FRAME];
            d.cmd_acc   = q.w_data[CMD_ACC_LO +: 2];
            d.pend      = 1'b1;
          end
        end
        REG_ROUTE: begin
          for (int b = 0; b < 3; b++) begin
            if (q.w_strb[b]) begin
              d.route[8*b +: 8] = q.w_data[8*b +: 8];
            end
          end
          // Top byte holds only the class bits and the source id
          if (q.w_strb[3]) begin
            d.route[ROUTE_W-1:24] = q.w_data[ROUTE_W-1:24];
          end
        end
        REG_TX_DATA: begin
          for (int b = 0; b < 4; b++) begin
            if (q.w_strb[b]) begin
              d.tx_data[8*b +: 8] = q.w_data[8*b +: 8];
            end
          end
        end
        REG_STATUS: begin
          // Write one to clear; a new event below wins
          if (q.w_strb[0]) begin
            d.rx_valid   = q.rx_valid & !q.w_data[STAT_RXV];
            d.abort_seen = q.abort_seen & !q.w_data[STAT_ABORT];
            d.resv_seen  = q.resv_seen & !q.w_data[STAT_RESV];
          end
        end
        REG_RX_WORD, REG_RX_INFO: d.bresp = RESP_OKAY;
        default:                  d.bresp = RESP_SLVERR;
      endcase
    end

    // Receive: two-stage synchronisers, then edge and period tracking
    d.ck_m   = dn_link_clk_in;
    d.ck_s   = q.ck_m;
    d.ck_p   = q.ck_s;
    d.bus_m  = downstream_subsymbol_bus_in;
    d.bus_s  = q.bus_m;
    d.rx_new = 1'b0;
    d.rx_cnt = (q.rx_cnt == CNT_MAX) ? CNT_MAX : q.rx_cnt + 8'h1;
    if (ck_rise) begin
      d.period  = (q.rx_cnt == CNT_MAX) ? q.period : q.rx_cnt + 8'h1;
      d.rx_cnt  = 8'h0;
      d.rx_slot = 3'h0;
    end else if (q.period != 8'h0 && q.rx_slot <= LAST_SLOT &&
                 q.rx_slot != 3'h7 && smp_lhs >= smp_rhs) begin
      d.rx_sh   = {q.rx_sh[SYM_W-SUB_W-1:0], q.bus_s};
      d.rx_slot = q.rx_slot + 3'h1;
      if (q.rx_slot == LAST_SLOT) begin
        d.rx_sym  = {q.rx_sh[SYM_W-SUB_W-1:0], q.bus_s};
        d.rx_new  = 1'b1;
        d.rx_slot = 3'h7;
      end
    end

    // Status events set sticky bits
    if (q.rx_new) begin
      d.rx_valid = 1'b1;
      if (sym.rx_abort) begin
        d.abort_seen = 1'b1;
      end
      if (sym.rx_resv_conn) begin
        d.resv_seen = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      q           <= '0;
      q.route     <= ROUTE_BLANK;
      q.tx_data   <= WORD_RST;
      q.sub_cnt   <= SUB_CYCLES - 4'h1;
      q.slot      <= LAST_SLOT;
      q.rx_slot   <= 3'h7;
    end else begin
      q <= d;
    end
  end

  sequence s_abort_in;
    q.rx_new && sym.rx_abort;
  endsequence

  a_kind_first_slot: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    sym_start |=> upstream_subsymbol_bus_out[SUB_W-1 -: 2] == $past(sym.tx_kind))
    else $error("kind not in first sub-symbol");

  a_null_when_idle: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    sym_start && !q.pend |=> upstream_subsymbol_bus_out[SUB_W-1 -: 3] == 3'b111)
    else $error("idle slot did not carry a null");

  a_clock_marks_t: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $rose(up_link_clk_out) |-> q.slot == 3'h0 && q.sub_cnt == 4'h0)
    else $error("link clock edge not at slot t");

  a_abort_sticky: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_abort_in |=> q.abort_seen [*2])
    else $error("abort not latched");

  a_resv_class: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    q.rx_new && sym.rx_kind == KIND_HEAD && sym.rx_conn[1] |=> q.resv_seen)
    else $error("reserved class not flagged");
endmodule // rsfc_ring_host
`default_nettype wire
